/* logic/dbr_consts.svh */
`ifndef DBR_CONSTS_SVH
`define DBR_CONSTS_SVH

// host i/o ports of the index/data pair
`define DBR_PORT_INDEX 16'h0022
`define DBR_PORT_DATA 16'h0023

// configuration indices
`define DBR_IDX_LOCK 8'h03
`define DBR_IDX_GEOM01 8'h10
`define DBR_IDX_GEOM23 8'h11
`define DBR_IDX_ROMCTL 8'h12

// unlock key and reset values
`define DBR_UNLOCK_KEY 8'hc5
`define DBR_RST_LOCK 8'h00
`define DBR_RST_INDEX 8'h00
`define DBR_RST_GEOM01 8'hf1
`define DBR_RST_GEOM23 8'hff
`define DBR_RST_ROMCTL 8'h00
`define DBR_READ_NONE 8'h00

// geometry code of an empty bank
`define DBR_CODE_EMPTY 4'hf

// field positions of the rom region and refresh control register
`define DBR_BIT_E_ROM 0
`define DBR_BIT_C_LOWER_ROM 1
`define DBR_BIT_C_UPPER_ROM 2
`define DBR_BIT_15M_ISA 3
`define DBR_BIT_FLASH 4
`define DBR_BIT_SWAP 5
`define DBR_BIT_RAS_TMO 6
`define DBR_BIT_HID_REF 7

// legacy memory windows
`define DBR_E_LO 32'h000e_0000
`define DBR_E_HI 32'h000e_ffff
`define DBR_C_LOWER_LO 32'h000c_0000
`define DBR_C_LOWER_HI 32'h000c_7fff
`define DBR_C_UPPER_LO 32'h000c_8000
`define DBR_C_UPPER_HI 32'h000c_ffff
`define DBR_15M_LO 32'h00f0_0000
`define DBR_15M_HI 32'h00ff_ffff

`endif

/* logic/dbr_pkg.sv */
package dbr_pkg;
   typedef logic [7:0] dbr_byte_t;
   typedef logic [3:0] dbr_code_t;
   typedef logic [3:0] dbr_bits_t;
   typedef logic [6:0] dbr_size_t;
   typedef logic [31:0] dbr_addr_t;
endpackage

/* logic/dbr_geom_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dbr_geom_if;
   import dbr_pkg::*;
   dbr_code_t code;
   dbr_bits_t row_address_bits;
   dbr_bits_t column_address_bits;
   dbr_size_t size_mb;
   logic present;
   logic reserved;
   modport ctrl (output code, input row_address_bits, column_address_bits, size_mb, present, reserved);
   modport dec (input code, output row_address_bits, column_address_bits, size_mb, present, reserved);
endinterface
`default_nettype wire

/* logic/dbr_geom_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dbr_consts.svh"
module dbr_geom_decode (
   dbr_geom_if.dec geom_if
);
   import dbr_pkg::*;

   // size in megabytes, then row/column widths per geometry code
   always_comb begin
      geom_if.present = 1'b1;
      geom_if.reserved = 1'b0;
      geom_if.size_mb = 7'h00;
      geom_if.row_address_bits = 4'h0;
      geom_if.column_address_bits = 4'h0;
      case (geom_if.code)
         4'h0: begin geom_if.size_mb = 7'h01; geom_if.row_address_bits = 4'h9; geom_if.column_address_bits = 4'h9; end
         4'h1: begin geom_if.size_mb = 7'h04; geom_if.row_address_bits = 4'ha; geom_if.column_address_bits = 4'ha; end
         4'h2: begin geom_if.size_mb = 7'h02; geom_if.row_address_bits = 4'h9; geom_if.column_address_bits = 4'ha; end
         4'h3: begin geom_if.size_mb = 7'h10; geom_if.row_address_bits = 4'hb; geom_if.column_address_bits = 4'hb; end
         4'h4: begin geom_if.size_mb = 7'h40; geom_if.row_address_bits = 4'hc; geom_if.column_address_bits = 4'hc; end
         4'h5: begin geom_if.size_mb = 7'h08; geom_if.row_address_bits = 4'hb; geom_if.column_address_bits = 4'ha; end
         4'h6: begin geom_if.size_mb = 7'h10; geom_if.row_address_bits = 4'hc; geom_if.column_address_bits = 4'ha; end
         4'h7: begin geom_if.size_mb = 7'h08; geom_if.row_address_bits = 4'hc; geom_if.column_address_bits = 4'h9; end
         4'h8: begin geom_if.size_mb = 7'h04; geom_if.row_address_bits = 4'hc; geom_if.column_address_bits = 4'h8; end
         `DBR_CODE_EMPTY: begin
            geom_if.present = 1'b0;
         end
         default: begin
            // reserved codes: treated as absent so no address is generated
            geom_if.present = 1'b0;
            geom_if.reserved = 1'b1;
         end
      endcase
   end
endmodule
`default_nettype wire

/* logic/dbr_config_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dbr_consts.svh"
// Overview of operation
// - index 10h bits 3:0 are bank 0 code
// - index 10h bits 7:4 are bank 1 code
// - index 11h bits 3:0 are bank 2 code
// - index 11h bits 7:4 are bank 3 code
// - bank code maps to bank size, empty or reserved
// - bank code maps to row/column address widths
// - bit 0 makes E region on-board ROM
// - bit 1 makes lower C region ROM
// - bit 2 makes upper C region ROM
// - bit 3 sends 15M region to ISA
// - bit 4 enables flash ROM writes
// - bit 5 swaps special cycle memory/IO qualifier
// - bit 6 enables row strobe timeout check
// - bit 7 enables hidden DRAM refresh
// - marked region asserts ROM select, else ISA
// - ROM writes select ROM only with flash
// - swap gives memory code write, else IO
// - registers open only after C5h lock write
module dbr_config_bank (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [15:0] io_addr_in,
   input wire dbr_pkg::dbr_byte_t io_wdata_in,
   output var dbr_pkg::dbr_byte_t io_rdata_out,
   output logic io_rdata_valid_out,
   input wire logic mem_cycle_in,
   input wire logic mem_write_in,
   input wire dbr_pkg::dbr_addr_t mem_addr_in,
   input wire logic special_cycle_in,
   input wire logic memory_io_qualifier_in,
   output logic boot_rom_select_n_out,
   output logic isa_cycle_out,
   output logic spec_mem_code_write_out,
   output logic spec_io_code_write_out,
   output logic [15:0] bank_row_address_bits_out,
   output logic [15:0] bank_column_address_bits_out,
   output logic [27:0] bank_size_mb_out,
   output logic [3:0] bank_present_out,
   output logic [3:0] bank_reserved_out,
   output logic ras_timeout_check_en_out,
   output logic hidden_refresh_en_out,
   output logic regs_unlocked_out
);
   import dbr_pkg::*;

   function automatic logic in_window(input dbr_addr_t a, input dbr_addr_t lo, input dbr_addr_t hi);
      return (a >= lo) && (a <= hi);
   endfunction

   dbr_byte_t index_r;
   dbr_byte_t lock_r;
   dbr_byte_t geom01_r;
   dbr_byte_t geom23_r;
   dbr_byte_t romctl_r;
   dbr_byte_t index_nxt;
   dbr_byte_t lock_nxt;
   dbr_byte_t geom01_nxt;
   dbr_byte_t geom23_nxt;
   dbr_byte_t romctl_nxt;
   dbr_byte_t rdata_r;
   dbr_byte_t rd_mux;
   logic rvalid_r;
   logic unlocked;
   logic wr_index;
   logic wr_data;
   logic wr_lock;
   logic wr_geom01;
   logic wr_geom23;
   logic wr_romctl;
   logic rd_ours;

   // register port decode
   assign unlocked = (lock_r == `DBR_UNLOCK_KEY);
   assign wr_index = io_wr_in && (io_addr_in == `DBR_PORT_INDEX);
   assign wr_data = io_wr_in && (io_addr_in == `DBR_PORT_DATA);
   // the lock register stays reachable while locked, otherwise no way back in
   assign wr_lock = wr_data && (index_r == `DBR_IDX_LOCK);
   assign wr_geom01 = wr_data && unlocked && (index_r == `DBR_IDX_GEOM01);
   assign wr_geom23 = wr_data && unlocked && (index_r == `DBR_IDX_GEOM23);
   assign wr_romctl = wr_data && unlocked && (index_r == `DBR_IDX_ROMCTL);
   assign rd_ours = io_rd_in && ((io_addr_in == `DBR_PORT_INDEX) || (io_addr_in == `DBR_PORT_DATA));

   assign index_nxt = wr_index ? io_wdata_in : index_r;
   assign lock_nxt = wr_lock ? io_wdata_in : lock_r;
   assign geom01_nxt = wr_geom01 ? io_wdata_in : geom01_r;
   assign geom23_nxt = wr_geom23 ? io_wdata_in : geom23_r;
   assign romctl_nxt = wr_romctl ? io_wdata_in : romctl_r;

   // locked or foreign indices read as zero
   assign rd_mux = (io_addr_in == `DBR_PORT_INDEX) ? index_r :
                   (index_r == `DBR_IDX_LOCK) ? lock_r :
                   !unlocked ? `DBR_READ_NONE :
                   (index_r == `DBR_IDX_GEOM01) ? geom01_r :
                   (index_r == `DBR_IDX_GEOM23) ? geom23_r :
                   (index_r == `DBR_IDX_ROMCTL) ? romctl_r : `DBR_READ_NONE;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         index_r <= `DBR_RST_INDEX;
         lock_r <= `DBR_RST_LOCK;
         geom01_r <= `DBR_RST_GEOM01;
         geom23_r <= `DBR_RST_GEOM23;
         romctl_r <= `DBR_RST_ROMCTL;
      end else begin
         index_r <= index_nxt;
         lock_r <= lock_nxt;
         geom01_r <= geom01_nxt;
         geom23_r <= geom23_nxt;
         romctl_r <= romctl_nxt;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_r <= `DBR_READ_NONE;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rd_ours ? rd_mux : rdata_r;
         rvalid_r <= rd_ours;
      end
   end

   assign io_rdata_out = rdata_r;
   assign io_rdata_valid_out = rvalid_r;
   assign regs_unlocked_out = unlocked;
   assign ras_timeout_check_en_out = romctl_r[`DBR_BIT_RAS_TMO];
   assign hidden_refresh_en_out = romctl_r[`DBR_BIT_HID_REF];

   // bank geometry: four decoders, outputs registered
   logic [15:0] bank_codes;
   logic [15:0] row_w;
   logic [15:0] col_w;
   logic [27:0] size_w;
   logic [3:0] present_w;
   logic [3:0] reserved_w;

   assign bank_codes = {geom23_r, geom01_r};

   for (genvar b = 0; b < 4; b++) begin : g_bank
      dbr_geom_if geom_if ();
      assign geom_if.code = bank_codes[4*b +: 4];
      dbr_geom_decode u_dec (
         .geom_if(geom_if.dec)
      );
      assign row_w[4*b +: 4] = geom_if.row_address_bits;
      assign col_w[4*b +: 4] = geom_if.column_address_bits;
      assign size_w[7*b +: 7] = geom_if.size_mb;
      assign present_w[b] = geom_if.present;
      assign reserved_w[b] = geom_if.reserved;
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bank_row_address_bits_out <= 16'h0000;
         bank_column_address_bits_out <= 16'h0000;
         bank_size_mb_out <= 28'h000_0000;
         bank_present_out <= 4'h0;
         bank_reserved_out <= 4'h0;
      end else begin
         bank_row_address_bits_out <= row_w;
         bank_column_address_bits_out <= col_w;
         bank_size_mb_out <= size_w;
         bank_present_out <= present_w;
         bank_reserved_out <= reserved_w;
      end
   end

   // memory and special cycle decode
   logic hit_e;
   logic hit_c_lower;
   logic hit_c_upper;
   logic hit_15m;
   logic legacy_hit;
   logic rom_marked;
   logic rom_sel_nxt;
   logic isa_nxt;
   logic qual_eff;
   logic spec_mem_nxt;
   logic spec_io_nxt;

   assign hit_e = in_window(mem_addr_in, `DBR_E_LO, `DBR_E_HI);
   assign hit_c_lower = in_window(mem_addr_in, `DBR_C_LOWER_LO, `DBR_C_LOWER_HI);
   assign hit_c_upper = in_window(mem_addr_in, `DBR_C_UPPER_LO, `DBR_C_UPPER_HI);
   assign hit_15m = in_window(mem_addr_in, `DBR_15M_LO, `DBR_15M_HI);
   assign legacy_hit = hit_e || hit_c_lower || hit_c_upper;
   assign rom_marked = (hit_e && romctl_r[`DBR_BIT_E_ROM]) ||
                       (hit_c_lower && romctl_r[`DBR_BIT_C_LOWER_ROM]) ||
                       (hit_c_upper && romctl_r[`DBR_BIT_C_UPPER_ROM]);
   // writes to rom need flash support; a blocked write gets neither target
   assign rom_sel_nxt = mem_cycle_in && rom_marked && (!mem_write_in || romctl_r[`DBR_BIT_FLASH]);
   // the 15M hole wins over local dram even when dram reaches past it
   assign isa_nxt = mem_cycle_in && ((legacy_hit && !rom_marked) || (hit_15m && romctl_r[`DBR_BIT_15M_ISA]));
   // special cycles carry the qualifier low, so the swap alone picks memory
   assign qual_eff = memory_io_qualifier_in ^ romctl_r[`DBR_BIT_SWAP];
   assign spec_mem_nxt = special_cycle_in && qual_eff;
   assign spec_io_nxt = special_cycle_in && !qual_eff;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         boot_rom_select_n_out <= 1'b1;
         isa_cycle_out <= 1'b0;
         spec_mem_code_write_out <= 1'b0;
         spec_io_code_write_out <= 1'b0;
      end else begin
         boot_rom_select_n_out <= !rom_sel_nxt;
         isa_cycle_out <= isa_nxt;
         spec_mem_code_write_out <= spec_mem_nxt;
         spec_io_code_write_out <= spec_io_nxt;
      end
   end

   // checks
   a_bank0_code_write: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      wr_geom01 |=> (geom01_r[3:0] == $past(io_wdata_in[3:0]))
         ##1 (bank_present_out[0] == ($past(geom01_r[3:0]) <= 4'h8)))
      else $error("bank 0 code not taken from data port");

   a_bank1_code_write: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      wr_geom01 |=> (bank_codes[7:4] == $past(io_wdata_in[7:4])))
      else $error("bank 1 code not taken from data port");

   a_bank2_code_write: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      wr_geom23 |=> (bank_codes[11:8] == $past(io_wdata_in[3:0])))
      else $error("bank 2 code not taken from data port");

   a_bank3_code_write: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      wr_geom23 |=> (bank_codes[15:12] == $past(io_wdata_in[7:4])))
      else $error("bank 3 code not taken from data port");

   a_bank_size_decode: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (bank_codes[3:0] == 4'h4) |=> (bank_size_mb_out[6:0] == 7'h40) && bank_present_out[0])
      else $error("code 4 does not give a 64M bank");

   a_bank_empty_decode: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (bank_codes[7:4] == `DBR_CODE_EMPTY) |=> !bank_present_out[1] && !bank_reserved_out[1])
      else $error("empty code shows a bank present");

   a_row_col_decode: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (bank_codes[11:8] == 4'h8) |=> (bank_row_address_bits_out[11:8] == 4'hc)
         && (bank_column_address_bits_out[11:8] == 4'h8))
      else $error("code 8 does not give 12/8 addressing");

   a_e_rom_select: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (mem_cycle_in && !mem_write_in && hit_e) |=> (boot_rom_select_n_out == !$past(romctl_r[`DBR_BIT_E_ROM])))
      else $error("E region rom select wrong");

   a_c_lower_rom: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (mem_cycle_in && !mem_write_in && hit_c_lower)
         |=> (boot_rom_select_n_out == !$past(romctl_r[`DBR_BIT_C_LOWER_ROM])))
      else $error("lower C region rom select wrong");

   a_c_upper_rom: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (mem_cycle_in && !mem_write_in && hit_c_upper)
         |=> (boot_rom_select_n_out == !$past(romctl_r[`DBR_BIT_C_UPPER_ROM])))
      else $error("upper C region rom select wrong");

   a_15m_to_isa: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (mem_cycle_in && hit_15m && romctl_r[`DBR_BIT_15M_ISA]) |=> isa_cycle_out && boot_rom_select_n_out)
      else $error("15M region not sent to isa");

   a_flash_write_gate: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (mem_cycle_in && mem_write_in && rom_marked) |=> (boot_rom_select_n_out != $past(romctl_r[`DBR_BIT_FLASH])))
      else $error("rom write select ignores flash enable");

   a_unmarked_isa: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (mem_cycle_in && legacy_hit && !rom_marked) |=> isa_cycle_out && boot_rom_select_n_out)
      else $error("unmarked legacy cycle not run on isa");

   a_special_swap: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (special_cycle_in && !memory_io_qualifier_in) |=>
         (spec_mem_code_write_out == $past(romctl_r[`DBR_BIT_SWAP])) && (spec_io_code_write_out != spec_mem_code_write_out))
      else $error("special cycle swap decode wrong");

   a_refresh_ras_bits: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      wr_romctl |=> (ras_timeout_check_en_out == $past(io_wdata_in[6])) && (hidden_refresh_en_out == $past(io_wdata_in[7])))
      else $error("timeout or hidden refresh enable not updated");

   a_locked_no_write: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (wr_data && !unlocked && (index_r != `DBR_IDX_LOCK)) |=> $stable(geom01_r) && $stable(geom23_r) && $stable(romctl_r))
      else $error("locked registers changed");

   a_locked_reads_zero: assert property (
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      (io_rd_in && (io_addr_in == `DBR_PORT_DATA) && !unlocked && (index_r != `DBR_IDX_LOCK))
         |=> io_rdata_valid_out && (io_rdata_out == `DBR_READ_NONE))
      else $error("locked register read not zero");
endmodule
`default_nettype wire

/* sim/dbr_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dbr_cpu_model (
   input wire logic ref_clk_in,
   output var logic mem_cycle_out,
   output var logic mem_write_out,
   output var dbr_pkg::dbr_addr_t mem_addr_out,
   output var logic special_cycle_out,
   output var logic memory_io_qualifier_out
);
   import dbr_pkg::*;
   initial begin
      mem_cycle_out = 1'b0;
      mem_write_out = 1'b0;
      mem_addr_out = 32'h0000_0000;
      special_cycle_out = 1'b0;
      memory_io_qualifier_out = 1'b1;
   end
   // an idle bus shows the inverse of the last address, so a stale decode cannot pass
   task automatic release_bus();
      mem_cycle_out = 1'b0;
      mem_write_out = ~mem_write_out;
      mem_addr_out = ~mem_addr_out;
      special_cycle_out = 1'b0;
      memory_io_qualifier_out = 1'b1;
   endtask
   // qualifier is low during a special cycle
   task automatic drive(input dbr_addr_t addr, input logic wr, input logic spec);
      @(negedge ref_clk_in);
      mem_cycle_out = ~spec;
      mem_write_out = wr;
      mem_addr_out = addr;
      special_cycle_out = spec;
      memory_io_qualifier_out = ~spec;
   endtask
endmodule
`default_nettype wire

/* sim/test_dram_bank_rom_region_config.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dbr_consts.svh"
module test_dram_bank_rom_region_config;
   import dbr_pkg::*;
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   dbr_byte_t io_wdata = 8'h00;
   dbr_byte_t rdata;
   logic rvalid, mcyc, mwr, spec, qual, sel_n, isa, spm, spi, ras_en, hid_en, unl;
   dbr_addr_t maddr;
   logic [15:0] rows, cols;
   logic [27:0] sizes;
   logic [3:0] pres, resv;
   int failures = 0;
   int n_checks = 0;
   int sz[9] = '{1, 4, 2, 16, 64, 8, 16, 8, 4};
   int rw[9] = '{9, 10, 9, 11, 12, 11, 12, 12, 12};
   int col_ref[9] = '{9, 10, 10, 11, 12, 10, 10, 9, 8};
   dbr_addr_t lo[3] = '{`DBR_E_LO, `DBR_C_LOWER_LO, `DBR_C_UPPER_LO};
   dbr_addr_t hi[3] = '{`DBR_E_HI, `DBR_C_LOWER_HI, `DBR_C_UPPER_HI};
   dbr_code_t c[4];
   always #25 ref_clk_in = ~ref_clk_in;
   dbr_cpu_model cpu (.ref_clk_in(ref_clk_in), .mem_cycle_out(mcyc), .mem_write_out(mwr), .mem_addr_out(maddr),
      .special_cycle_out(spec), .memory_io_qualifier_out(qual));
   dbr_config_bank DUT (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .io_wr_in(io_wr), .io_rd_in(io_rd),
      .io_addr_in(io_addr), .io_wdata_in(io_wdata), .io_rdata_out(rdata), .io_rdata_valid_out(rvalid),
      .mem_cycle_in(mcyc), .mem_write_in(mwr), .mem_addr_in(maddr), .special_cycle_in(spec),
      .memory_io_qualifier_in(qual), .boot_rom_select_n_out(sel_n), .isa_cycle_out(isa),
      .spec_mem_code_write_out(spm), .spec_io_code_write_out(spi), .bank_row_address_bits_out(rows),
      .bank_column_address_bits_out(cols), .bank_size_mb_out(sizes), .bank_present_out(pres),
      .bank_reserved_out(resv), .ras_timeout_check_en_out(ras_en), .hidden_refresh_en_out(hid_en),
      .regs_unlocked_out(unl));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (exp !== got) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic io_write(input logic [15:0] addr, input dbr_byte_t d);
      @(negedge ref_clk_in);
      io_wr = 1'b1;
      io_addr = addr;
      io_wdata = d;
      @(negedge ref_clk_in);
      io_wr = 1'b0;
      io_wdata = ~d;
   endtask
   task automatic io_read(input logic [15:0] addr, input dbr_byte_t exp, input logic v);
      @(negedge ref_clk_in);
      io_rd = 1'b1;
      io_addr = addr;
      @(negedge ref_clk_in);
      io_rd = 1'b0;
      check("read valid", {31'h0, v}, {31'h0, rvalid});
      if (v) check("read data", {24'h0, exp}, {24'h0, rdata});
   endtask
   task automatic reg_wr(input dbr_byte_t idx, input dbr_byte_t d);
      io_write(`DBR_PORT_INDEX, idx);
      io_write(`DBR_PORT_DATA, d);
      repeat (2) @(negedge ref_clk_in);
   endtask
   task automatic reg_rd(input dbr_byte_t idx, input dbr_byte_t exp);
      io_write(`DBR_PORT_INDEX, idx);
      io_read(`DBR_PORT_DATA, exp, 1'b1);
   endtask
   task automatic check_banks();
      int k;
      for (int b = 0; b < 4; b++) begin
         k = int'(c[b]);
         check("bank present", {31'h0, c[b] != `DBR_CODE_EMPTY}, {31'h0, pres[b]});
         check("bank reserved", 0, {31'h0, resv[b]});
         check("bank size", (k < 9) ? sz[k] : 0, {25'h0, sizes[7*b+:7]});
         check("bank rows", (k < 9) ? rw[k] : 0, {28'h0, rows[4*b+:4]});
         check("bank cols", (k < 9) ? col_ref[k] : 0, {28'h0, cols[4*b+:4]});
      end
   endtask
   task automatic mem_chk(input dbr_addr_t a, input logic wr, input logic exp_sel_n, input logic exp_isa);
      cpu.drive(a, wr, 1'b0);
      @(negedge ref_clk_in);
      check("rom select", {31'h0, exp_sel_n}, {31'h0, sel_n});
      check("isa cycle", {31'h0, exp_isa}, {31'h0, isa});
      cpu.release_bus();
   endtask
   task automatic spec_chk(input logic exp_mem);
      cpu.drive(32'h0000_0000, 1'b1, 1'b1);
      @(negedge ref_clk_in);
      check("spec memory write", {31'h0, exp_mem}, {31'h0, spm});
      check("spec io write", {31'h0, ~exp_mem}, {31'h0, spi});
      cpu.release_bus();
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge ref_clk_in);
      arst_n_in = 1'b1;
      @(negedge ref_clk_in);
      c = '{4'h1, 4'hf, 4'hf, 4'hf};
      check_banks();
      check("unlocked", 0, {31'h0, unl});
      reg_rd(`DBR_IDX_ROMCTL, 8'h00);
      reg_wr(`DBR_IDX_GEOM01, 8'h00);
      reg_wr(`DBR_IDX_LOCK, `DBR_UNLOCK_KEY);
      check("unlocked", 1, {31'h0, unl});
      reg_rd(`DBR_IDX_GEOM01, `DBR_RST_GEOM01);
      reg_rd(`DBR_IDX_GEOM23, `DBR_RST_GEOM23);
      reg_rd(`DBR_IDX_ROMCTL, `DBR_RST_ROMCTL);
      $display("test reset and lock done");
      // only listed codes are written; each bank gets a different one
      for (int k = 0; k < 10; k++) begin
         for (int b = 0; b < 4; b++) c[b] = ((k + b) % 10 == 9) ? 4'hf : 4'((k + b) % 10);
         reg_wr(`DBR_IDX_GEOM01, {c[1], c[0]});
         reg_wr(`DBR_IDX_GEOM23, {c[3], c[2]});
         check_banks();
         reg_rd(`DBR_IDX_GEOM23, {c[3], c[2]});
      end
      $display("test geometry done");
      for (int r = 0; r < 3; r++) begin
         reg_wr(`DBR_IDX_ROMCTL, 8'(1 << r));
         mem_chk(lo[r], 1'b0, 1'b0, 1'b0);
         mem_chk(hi[r], 1'b0, 1'b0, 1'b0);
         mem_chk(lo[(r + 1) % 3], 1'b0, 1'b1, 1'b1);
         reg_wr(`DBR_IDX_ROMCTL, 8'h00);
         mem_chk(hi[r], 1'b0, 1'b1, 1'b1);
      end
      reg_wr(`DBR_IDX_ROMCTL, 8'h07);
      mem_chk(32'h000b_ffff, 1'b0, 1'b1, 1'b0);
      mem_chk(32'h000d_0000, 1'b0, 1'b1, 1'b0);
      mem_chk(`DBR_E_LO, 1'b1, 1'b1, 1'b0);
      reg_wr(`DBR_IDX_ROMCTL, 8'h17);
      mem_chk(`DBR_E_LO, 1'b1, 1'b0, 1'b0);
      mem_chk(`DBR_C_UPPER_HI, 1'b1, 1'b0, 1'b0);
      reg_wr(`DBR_IDX_ROMCTL, 8'h08);
      mem_chk(`DBR_15M_LO, 1'b0, 1'b1, 1'b1);
      mem_chk(`DBR_15M_HI, 1'b1, 1'b1, 1'b1);
      mem_chk(32'h00ef_ffff, 1'b0, 1'b1, 1'b0);
      reg_wr(`DBR_IDX_ROMCTL, 8'h00);
      mem_chk(`DBR_15M_LO, 1'b0, 1'b1, 1'b0);
      $display("test memory decode done");
      spec_chk(1'b0);
      reg_wr(`DBR_IDX_ROMCTL, 8'h20);
      spec_chk(1'b1);
      for (int k = 6; k < 8; k++) begin
         reg_wr(`DBR_IDX_ROMCTL, 8'(1 << k));
         check("timeout check", {31'h0, k == 6}, {31'h0, ras_en});
         check("hidden refresh", {31'h0, k == 7}, {31'h0, hid_en});
      end
      $display("test special and enables done");
      reg_wr(`DBR_IDX_LOCK, 8'hc4);
      check("unlocked", 0, {31'h0, unl});
      reg_wr(`DBR_IDX_ROMCTL, 8'hff);
      reg_rd(`DBR_IDX_LOCK, 8'hc4);
      reg_wr(`DBR_IDX_LOCK, `DBR_UNLOCK_KEY);
      reg_rd(`DBR_IDX_ROMCTL, 8'h80);
      check("hidden refresh", 1, {31'h0, hid_en});
      reg_rd(8'h20, 8'h00);
      io_read(`DBR_PORT_INDEX, 8'h20, 1'b1);
      io_read(16'h0024, 8'h00, 1'b0);
      $display("test relock done");
      // a second reset must bring back the documented codes over programmed ones
      arst_n_in = 1'b0;
      @(negedge ref_clk_in);
      check("hidden refresh", 0, {31'h0, hid_en});
      arst_n_in = 1'b1;
      @(negedge ref_clk_in);
      c = '{4'h1, 4'hf, 4'hf, 4'hf};
      check_banks();
      check("unlocked", 0, {31'h0, unl});
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire
